/* File: inc/srs_pkg.sv */
// srs_pkg: constants and types shared by the switch reset sequencer
// assumes a single 125 MHz clock and a byte-addressed classic wishbone slave
package srs_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int DS_PORTS = 5;
  localparam int ADDR_W = 5;
  localparam int TIMER_W = 24;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SWITCH_CONTROL_REG_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] BOOT_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] SMBSTS_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] PHYLS_OFS = 5'h0c;
  localparam logic [ADDR_W-1:0] STICKY_OFS = 5'h10;
  localparam logic [ADDR_W-1:0] SEQ_OFS = 5'h14;
  localparam logic [ADDR_W-1:0] BRIDGE_OFS = 5'h18;
  localparam logic [ADDR_W-1:0] GPIO_OFS = 5'h1c;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SWITCH_CONTROL_REG_FULL_RESET_TRIGGER_BIT_BIT = 0;
  localparam int SWITCH_CONTROL_REG_HRST_BIT = 1;
  localparam int BRIDGE_USB_BIT = 0;
  localparam int BRIDGE_DSB_LSB = 8;
  localparam int GPIO_OE_LSB = 0;
  localparam int GPIO_OUT_LSB = 8;
  localparam int SMBSTS_DONE_BIT = 0;
  localparam int SMBSTS_ERR_BIT = 1;
  localparam int SMBSTS_CODE_LSB = 4;
  // ----------------------------------------------------------------
  // mode codes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_NVM = 3'h1;
  localparam logic [31:0] STICKY_RST = 32'h0000_0000;
  localparam logic [6:0] SSMB_ADDR_FIXED = 7'h00;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 125000;
  localparam int TRAIN_LIMIT_MS = 20;
  localparam int CFG_LIMIT_MS = 100;
  localparam int TRAIN_LIMIT_CYC = TRAIN_LIMIT_MS * CLK_KHZ;
  localparam int CFG_LIMIT_CYC = CFG_LIMIT_MS * CLK_KHZ;
  localparam int MSMB_SLOW_KHZ = 100;
  localparam int MSMB_FAST_KHZ = 400;
  // half period of the master serial clock in system cycles
  localparam logic [15:0] MSMB_DIV_SLOW = 16'(CLK_KHZ / (2 * MSMB_SLOW_KHZ));
  localparam logic [15:0] MSMB_DIV_FAST = 16'(CLK_KHZ / (2 * MSMB_FAST_KHZ));
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_FUND, ST_MODE, ST_PLL, ST_SMBF, ST_SSMB, ST_MSMB, ST_LOAD, ST_RUN, ST_HOT
  } srs_seq_type;
  typedef struct packed {
    logic [2:0] mode;
    logic slow;
    logic [3:0] saddr;
  } srs_boot_type;
  typedef struct packed {
    logic rst_n;
    srs_boot_type boot;
  } srs_pins_type;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } srs_wb_req_type;
  typedef struct packed {
    logic wr;
    logic last;
    logic err;
    logic [3:0] code;
    logic [ADDR_W-1:0] adr;
    logic [31:0] dat;
  } srs_nvm_type;
  typedef struct packed {
    srs_pins_type s1;
    srs_pins_type s2;
    srs_seq_type seq;
    srs_boot_type boot;
    logic pin_seen;
    logic nvm_mode;
    logic mode_bad;
    logic full_reset_trigger_bit_pend;
    logic hot_sw;
    logic pll_rst;
    logic train_en;
    logic stack_rst;
    logic cfg_retry;
    logic hot_pulse;
    logic [DS_PORTS-1:0] vbus_hot;
    logic [DS_PORTS-1:0] ds_hot;
    logic [DS_PORTS-1:0] retrain;
    logic [DS_PORTS-1:0] dsb;
    logic [DS_PORTS-1:0] gpio_oe;
    logic [DS_PORTS-1:0] gpio_out;
    logic usb;
    logic ssmb_rst;
    logic msmb_rst;
    logic msmb_slow;
    logic [15:0] msmb_div;
    logic [6:0] ssmb_addr;
    logic nvm_active;
    logic smb_done;
    logic smb_err;
    logic [3:0] smb_code;
    logic [TIMER_W-1:0] timer;
    logic train_late;
    logic cfg_late;
    logic [31:0] sticky;
    logic ack;
    logic [31:0] rdata;
  } srs_state_type;
endpackage : srs_pkg

/* File: logic/srs_sequencer.sv */
// srs_sequencer: reset sorting and bring-up sequencing for a switch
// assumes pins arrive asynchronously, all other inputs are on clk_i,
// and software reaches the registers over classic wishbone
`timescale 1ns/10ps
module srs_sequencer #(
  parameter int TRAIN_CYC = srs_pkg::TRAIN_LIMIT_CYC,
  parameter int CFG_CYC = srs_pkg::CFG_LIMIT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire srs_pkg::srs_wb_req_type wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // asynchronous reset and boot pins
  input wire srs_pkg::srs_pins_type pins_i,
  // link and pll status
  input wire logic pll_lock_i,
  input wire logic links_training_i,
  input wire logic link_hot_i,
  input wire logic [srs_pkg::DS_PORTS-1:0] link_up_i,
  // nvm loader
  input wire srs_pkg::srs_nvm_type nvm_i,
  output logic nvm_load_o,
  // pll, training and stacks
  output logic pll_rst_o,
  output logic train_en_o,
  output logic stack_rst_o,
  output logic cfg_retry_o,
  output logic hot_reset_o,
  output logic [srs_pkg::DS_PORTS-1:0] vbus_hot_reset_o,
  output logic [srs_pkg::DS_PORTS-1:0] ds_hot_reset_o,
  output logic [srs_pkg::DS_PORTS-1:0] retrain_o,
  // serial buses
  output logic ssmb_rst_o,
  output logic [6:0] ssmb_addr_o,
  output logic msmb_rst_o,
  output logic msmb_slow_o,
  output logic [15:0] msmb_div_o,
  // general-purpose port reset pins
  output logic [srs_pkg::DS_PORTS-1:0] gpio_oe_o,
  output logic [srs_pkg::DS_PORTS-1:0] gpio_out_o
);
  localparam int DS = srs_pkg::DS_PORTS;
  localparam int TW = srs_pkg::TIMER_W;

  srs_pkg::srs_state_type q;
  srs_pkg::srs_state_type d;
  logic fund;
  logic hot_go;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic srs_pkg::srs_state_type reset_state();
    srs_pkg::srs_state_type s;
    s = '0;
    s.seq = srs_pkg::ST_FUND;
    s.pll_rst = 1'b1;
    s.stack_rst = 1'b1;
    s.ssmb_rst = 1'b1;
    s.msmb_rst = 1'b1;
    s.msmb_div = srs_pkg::MSMB_DIV_FAST;
    s.ssmb_addr = srs_pkg::SSMB_ADDR_FIXED;
    s.sticky = srs_pkg::STICKY_RST;
    // synchroniser starts asserted so a power-up reset latches the boot pins too
    s.s1.rst_n = 1'b0;
    s.s2.rst_n = 1'b0;
    return s;
  endfunction : reset_state

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  // register write shared by software and the nvm loader
  function automatic srs_pkg::srs_state_type apply_write(
    input srs_pkg::srs_state_type s_in,
    input logic [srs_pkg::ADDR_W-1:0] a,
    input logic [31:0] v,
    input logic [3:0] sel
  );
    srs_pkg::srs_state_type s;
    logic [31:0] m;
    logic [31:0] w;
    s = s_in;
    m = lane_mask(sel);
    w = v & m;
    case (a)
      srs_pkg::SWITCH_CONTROL_REG_OFS:
      begin
        if (w[srs_pkg::SWITCH_CONTROL_REG_FULL_RESET_TRIGGER_BIT_BIT])
          s.full_reset_trigger_bit_pend = 1'b1;
        if (w[srs_pkg::SWITCH_CONTROL_REG_HRST_BIT])
          s.hot_sw = 1'b1;
      end
      srs_pkg::PHYLS_OFS:
        s.retrain = s.retrain | w[DS-1:0];
      srs_pkg::STICKY_OFS:
        s.sticky = (s.sticky & ~m) | w;
      srs_pkg::BRIDGE_OFS:
      begin
        if (m[srs_pkg::BRIDGE_USB_BIT])
          s.usb = v[srs_pkg::BRIDGE_USB_BIT];
        if (m[srs_pkg::BRIDGE_DSB_LSB])
          s.dsb = v[srs_pkg::BRIDGE_DSB_LSB +: DS];
      end
      srs_pkg::GPIO_OFS:
      begin
        if (m[srs_pkg::GPIO_OE_LSB])
          s.gpio_oe = v[srs_pkg::GPIO_OE_LSB +: DS];
        if (m[srs_pkg::GPIO_OUT_LSB])
          s.gpio_out = v[srs_pkg::GPIO_OUT_LSB +: DS];
      end
      default:
        s = s;
    endcase
    return s;
  endfunction : apply_write

  function automatic logic [31:0] rd_word(
    input srs_pkg::srs_state_type s,
    input logic [srs_pkg::ADDR_W-1:0] a
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      srs_pkg::SWITCH_CONTROL_REG_OFS:
        r = 32'h0000_0000;
      srs_pkg::BOOT_OFS:
        r = {19'h0_0000, s.mode_bad, s.nvm_mode, s.boot.saddr, s.boot.slow, s.boot.mode,
          s.ssmb_addr[6:4]};
      srs_pkg::SMBSTS_OFS:
      begin
        r[srs_pkg::SMBSTS_DONE_BIT] = s.smb_done;
        r[srs_pkg::SMBSTS_ERR_BIT] = s.smb_err;
        r[srs_pkg::SMBSTS_CODE_LSB +: 4] = s.smb_code;
      end
      srs_pkg::STICKY_OFS:
        r = s.sticky;
      srs_pkg::SEQ_OFS:
        r = {24'h00_0000, s.train_late, s.cfg_late, s.nvm_active, s.cfg_retry, s.seq};
      srs_pkg::BRIDGE_OFS:
      begin
        r[srs_pkg::BRIDGE_USB_BIT] = s.usb;
        r[srs_pkg::BRIDGE_DSB_LSB +: DS] = s.dsb;
      end
      srs_pkg::GPIO_OFS:
      begin
        r[srs_pkg::GPIO_OE_LSB +: DS] = s.gpio_oe;
        r[srs_pkg::GPIO_OUT_LSB +: DS] = s.gpio_out;
      end
      default:
        r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_word

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.s1 = pins_i;
    d.s2 = q.s1;
    d.ack = 1'b0;
    d.hot_sw = 1'b0;
    d.hot_pulse = 1'b0;
    d.retrain = '0;
    fund = ~q.s2.rst_n | q.full_reset_trigger_bit_pend;
    hot_go = (link_hot_i | q.hot_sw) & (q.seq == srs_pkg::ST_RUN);
    if (fund)
    begin
      // everything returns to initial values except the boot latch and pin_seen; the pin synchroniser keeps sampling
      d = reset_state();
      d.s1 = pins_i;
      d.s2 = q.s1;
      d.boot = q.boot;
      d.pin_seen = q.pin_seen | ~q.s2.rst_n;
    end
    else
    begin
      if (q.timer != TW'(CFG_CYC))
        d.timer = q.timer + 1'b1;
      if (q.timer == TW'(TRAIN_CYC) && !links_training_i)
        d.train_late = 1'b1;
      if (q.timer == TW'(CFG_CYC) && q.stack_rst)
        d.cfg_late = 1'b1;
      case (q.seq)
        srs_pkg::ST_FUND:
        begin
          // pin release latches boot values; a software reset keeps the old ones
          if (q.pin_seen)
            d.boot = q.s2.boot;
          d.pin_seen = 1'b0;
          d.seq = srs_pkg::ST_MODE;
        end
        srs_pkg::ST_MODE:
        begin
          d.nvm_mode = (q.boot.mode == srs_pkg::MODE_NVM);
          d.mode_bad = (q.boot.mode != srs_pkg::MODE_NORMAL) &&
            (q.boot.mode != srs_pkg::MODE_NVM);
          d.pll_rst = 1'b0;
          d.seq = srs_pkg::ST_PLL;
        end
        srs_pkg::ST_PLL:
          if (pll_lock_i)
          begin
            // training starts; the sequence goes on without waiting for it
            d.train_en = 1'b1;
            d.stack_rst = 1'b0;
            d.cfg_retry = 1'b1;
            d.seq = srs_pkg::ST_SMBF;
          end
        srs_pkg::ST_SMBF:
        begin
          d.msmb_slow = q.boot.slow;
          d.msmb_div = q.boot.slow ? srs_pkg::MSMB_DIV_SLOW : srs_pkg::MSMB_DIV_FAST;
          d.seq = srs_pkg::ST_SSMB;
        end
        srs_pkg::ST_SSMB:
        begin
          d.ssmb_rst = 1'b0;
          d.ssmb_addr = srs_pkg::SSMB_ADDR_FIXED | {1'b0, q.boot.saddr[3], 1'b0,
            q.boot.saddr[2:0], 1'b0};
          d.seq = srs_pkg::ST_MSMB;
        end
        srs_pkg::ST_MSMB:
        begin
          d.msmb_rst = 1'b0;
          d.nvm_active = q.nvm_mode;
          d.seq = q.nvm_mode ? srs_pkg::ST_LOAD : srs_pkg::ST_RUN;
        end
        srs_pkg::ST_LOAD:
        begin
          d.cfg_retry = 1'b1;
          if (nvm_i.err)
          begin
            d.smb_err = 1'b1;
            d.smb_code = nvm_i.code;
          end
          if (nvm_i.err || (nvm_i.wr && nvm_i.last))
          begin
            d.smb_done = 1'b1;
            d.nvm_active = 1'b0;
            d.seq = srs_pkg::ST_RUN;
          end
        end
        srs_pkg::ST_RUN:
          d.cfg_retry = 1'b0;
        srs_pkg::ST_HOT:
        begin
          d.stack_rst = 1'b0;
          d.cfg_retry = 1'b0;
          d.seq = srs_pkg::ST_RUN;
        end
        default:
          d.seq = srs_pkg::ST_FUND;
      endcase
      // wishbone: registered ack, write committed as ack is raised
      if (wb_i.cyc && wb_i.stb && !q.ack)
      begin
        d.ack = 1'b1;
        d.rdata = rd_word(q, wb_i.adr);
        if (wb_i.we)
          d = apply_write(d, wb_i.adr, wb_i.dat, wb_i.sel);
      end
      // loaded words go through the same write path, effects at once
      if (q.seq == srs_pkg::ST_LOAD && nvm_i.wr && !nvm_i.err)
        d = apply_write(d, nvm_i.adr, nvm_i.dat, 4'hf);
      if (hot_go)
      begin
        // bridge, gpio and retrain fields back to initial values; sticky, smb status, timer, pll and serial buses kept
        d.usb = 1'b0;
        d.dsb = '0;
        d.gpio_oe = '0;
        d.gpio_out = '0;
        d.retrain = '0;
        d.full_reset_trigger_bit_pend = 1'b0;
        d.hot_pulse = 1'b1;
        d.stack_rst = 1'b1;
        d.cfg_retry = 1'b1;
        d.seq = srs_pkg::ST_HOT;
      end
      d.vbus_hot = {DS{d.usb | hot_go}};
      d.ds_hot = d.dsb | (hot_go ? link_up_i : '0);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= reset_state();
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;
  assign nvm_load_o = q.nvm_active;
  assign pll_rst_o = q.pll_rst;
  assign train_en_o = q.train_en;
  assign stack_rst_o = q.stack_rst;
  assign cfg_retry_o = q.cfg_retry;
  assign hot_reset_o = q.hot_pulse;
  assign vbus_hot_reset_o = q.vbus_hot;
  assign ds_hot_reset_o = q.ds_hot;
  assign retrain_o = q.retrain;
  assign ssmb_rst_o = q.ssmb_rst;
  assign ssmb_addr_o = q.ssmb_addr;
  assign msmb_rst_o = q.msmb_rst;
  assign msmb_slow_o = q.msmb_slow;
  assign msmb_div_o = q.msmb_div;
  assign gpio_oe_o = q.gpio_oe;
  assign gpio_out_o = q.gpio_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_FUND_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
    !q.s2.rst_n |=> q.seq == srs_pkg::ST_FUND && !q.usb && q.sticky == srs_pkg::STICKY_RST)
    else $error("fundamental reset left state behind");
  AST_HOT_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    hot_go && !fund |=> q.sticky == $past(q.sticky) && q.dsb == '0 && q.hot_pulse)
    else $error("hot reset lost sticky field or kept plain field");
  AST_USB_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    q.usb |-> q.vbus_hot == {DS{1'b1}} && !q.hot_pulse)
    else $error("upstream secondary reset not passed to internal devices");
  AST_DSB_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    q.dsb != '0 |-> (q.ds_hot & q.dsb) == q.dsb)
    else $error("downstream secondary reset not propagated");
  AST_SW_FULL_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
    q.full_reset_trigger_bit_pend |-> q.ack ##1 (q.seq == srs_pkg::ST_FUND && !q.ack))
    else $error("full reset began before the write was acknowledged");
  AST_BOOT_LATCH: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == srs_pkg::ST_FUND && !fund |=>
      q.boot == ($past(q.pin_seen) ? $past(q.s2.boot) : $past(q.boot)))
    else $error("boot values latched wrongly");
  AST_MODE_DECODE: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == srs_pkg::ST_MODE && !fund |=> q.nvm_mode == (q.boot.mode == srs_pkg::MODE_NVM))
    else $error("operating mode decoded wrongly");
  AST_PLL_TRAIN: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == srs_pkg::ST_PLL && pll_lock_i && !fund |=>
      q.train_en && !q.stack_rst && q.cfg_retry)
    else $error("training or quasi reset not started after lock");
  AST_SMB_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == srs_pkg::ST_SMBF && !fund |=> q.msmb_slow == $past(q.boot.slow) &&
      q.ssmb_rst ##1 (!q.ssmb_rst && q.msmb_rst) ##1 !q.msmb_rst)
    else $error("serial buses released out of order");
  AST_LOAD_RETRY: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == srs_pkg::ST_LOAD |-> q.cfg_retry)
    else $error("config not retried during load");
  AST_LOAD_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == srs_pkg::ST_LOAD && nvm_i.err && !fund && !hot_go |=>
      q.smb_done && q.smb_err && q.seq == srs_pkg::ST_RUN ##1 !q.cfg_retry)
    else $error("load error not recorded or load not ended");
  AST_RETRAIN_NOW: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == srs_pkg::ST_LOAD && nvm_i.wr && !nvm_i.err && !fund &&
      nvm_i.adr == srs_pkg::PHYLS_OFS |=> q.retrain == $past(nvm_i.dat[DS-1:0]))
    else $error("retrain not started at the loaded write");
  AST_GPIO_INPUT: assert property (@(posedge clk_i) disable iff (rst_i)
    q.seq == srs_pkg::ST_FUND |-> q.gpio_oe == '0)
    else $error("port reset pin driven during fundamental reset");
endmodule : srs_sequencer

/* File: testbench/srs_far_model.sv */
// srs_far_model: pll lock and serial nvm loader beside the sequencer
// assumes the loader is started by nvm_load_i and runs on clk_i
`timescale 1ns/10ps
module srs_far_model (
  // clock and control
  input wire logic clk_i,
  input wire logic pll_rst_i,
  input wire logic nvm_load_i,
  input wire logic err_i,
  // answers
  output logic pll_lock_o,
  output srs_pkg::srs_nvm_type nvm_o
);
  logic [7:0] lk = 8'h00;
  logic [7:0] ld = 8'h00;
  srs_pkg::srs_nvm_type q = '0;
  assign pll_lock_o = (lk == 8'h08);
  assign nvm_o = q;
  // image: config word, retrain word, closing config word or error
  always @(posedge clk_i)
  begin
    lk <= pll_rst_i ? 8'h00 : ((lk == 8'h08) ? lk : lk + 8'h01);
    ld <= nvm_load_i ? ld + 8'h01 : 8'h00;
    q.wr <= (ld == 8'h04) || (ld == 8'h08) || (ld == 8'h0c && !err_i);
    q.last <= (ld == 8'h0c);
    q.err <= (ld == 8'h0c) && err_i;
    q.code <= 4'h3;
    q.adr <= (ld == 8'h08) ? srs_pkg::PHYLS_OFS : srs_pkg::STICKY_OFS;
    // idle data toggles so a stale word never looks valid
    q.dat <= (ld == 8'h08) ? 32'h0000_0001 :
      ((ld == 8'h04 || ld == 8'h0c) ? 32'h0000_a5a5 : ~q.dat);
  end
endmodule : srs_far_model

/* File: testbench/switch_reset_sequencer_tb.sv */
// switch_reset_sequencer_tb: self-checking bench for the reset sequencer
// assumes srs_pkg, srs_sequencer and srs_far_model are compiled first
`timescale 1ns/10ps
module switch_reset_sequencer_tb;
  typedef struct packed {
    logic [4:0] a;
    logic [31:0] r0;
    logic [31:0] w;
    logic [31:0] r1;
  } srs_row_type;
  localparam srs_row_type ROWS [6] = '{
    '{5'h04, 32'h0000_0d4a, 32'hffff_ffff, 32'h0000_0d4a},
    '{5'h08, 32'h0000_0001, 32'hffff_ffff, 32'h0000_0001},
    '{5'h10, 32'h0000_a5a5, 32'h1234_5678, 32'h1234_5678},
    '{5'h0c, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000},
    '{5'h1c, 32'h0000_0000, 32'hffff_ffff, 32'h0000_1f1f},
    '{5'h02, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0000}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  srs_pkg::srs_wb_req_type wb = '0;
  srs_pkg::srs_pins_type pins = '{1'b0, '{3'h1, 1'b1, 4'ha}};
  logic trn = 1'b0;
  logic nerr = 1'b0;
  logic [4:0] lup = 5'h00;
  logic ack, nload, pllr, trn_en, srst, retry, hot, sr, mr, slow, lock;
  logic [31:0] rd;
  logic [31:0] q;
  logic [4:0] vb, ds, rt, oe, gout, ds_at, vb_at;
  logic [15:0] div;
  logic [6:0] sa;
  srs_pkg::srs_nvm_type nvm;
  logic hot_seen = 1'b0;
  logic rt_load = 1'b0;
  logic ord_bad = 1'b0;
  logic lhot = 1'b0;
  int err_count = 0;
  int compares = 0;
  srs_sequencer #(.TRAIN_CYC(50), .CFG_CYC(200)) dut (.clk_i(clk), .rst_i(rst), .wb_i(wb),
    .wb_ack_o(ack), .wb_dat_o(rd), .pins_i(pins), .pll_lock_i(lock), .links_training_i(trn),
    .link_hot_i(lhot), .link_up_i(lup), .nvm_i(nvm), .nvm_load_o(nload), .pll_rst_o(pllr),
    .train_en_o(trn_en), .stack_rst_o(srst), .cfg_retry_o(retry), .hot_reset_o(hot),
    .vbus_hot_reset_o(vb), .ds_hot_reset_o(ds), .retrain_o(rt), .ssmb_rst_o(sr),
    .ssmb_addr_o(sa), .msmb_rst_o(mr), .msmb_slow_o(slow), .msmb_div_o(div),
    .gpio_oe_o(oe), .gpio_out_o(gout));
  srs_far_model far (.clk_i(clk), .pll_rst_i(pllr), .nvm_load_i(nload), .err_i(nerr),
    .pll_lock_o(lock), .nvm_o(nvm));
  initial
  begin
    forever #4 clk = ~clk;
  end
  // ----
  // monitors for pulses and ordering
  // ----
  always @(posedge clk)
  begin
    trn <= trn_en;
    if (hot === 1'b1)
    begin
      hot_seen <= 1'b1;
      ds_at <= ds;
      vb_at <= vb;
    end
    if (rt[0] === 1'b1 && nload === 1'b1) rt_load <= 1'b1;
    if (mr === 1'b0 && sr === 1'b1) ord_bad <= 1'b1;
  end
  task automatic test_done;
    begin
      $display("errors=%0d compares=%0d", err_count, compares);
      if (err_count == 0 && compares > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      compares++;
      if (got !== exp)
      begin
        err_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask : chk
  task automatic wbx(input logic w, input logic [4:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    begin
      n = 0;
      wb <= '{1'b1, 1'b1, w, a, 4'hf, d};
      @(posedge clk);
      while (ack !== 1'b1 && n < 64)
      begin
        @(posedge clk);
        n++;
      end
      r = rd;
      wb.cyc <= 1'b0;
      wb.stb <= 1'b0;
      @(posedge clk);
      if (n == 64)
      begin
        err_count++;
        test_done();
      end
    end
  endtask : wbx
  task automatic waitl(input logic v);
    int n;
    begin
      n = 0;
      while (nload !== v && n < 4000)
      begin
        @(posedge clk);
        n++;
      end
      if (n == 4000)
      begin
        err_count++;
        test_done();
      end
    end
  endtask : waitl
  // ----
  // main sequence
  // ----
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'({oe, pllr, div}), 32'h0001_009c);
    repeat (4) @(posedge clk);
    pins.rst_n <= 1'b1;
    waitl(1'b1);
    chk(32'({trn_en, srst, retry, slow, sr, mr}), 32'h2c);
    chk({div, 16'(sa)}, 32'h0271_0024);
    waitl(1'b0);
    chk(32'(rt_load), 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(retry), 32'h0);
    foreach (ROWS[i])
    begin
      wbx(1'b0, ROWS[i].a, 32'h0, q);
      chk(q, ROWS[i].r0);
      wbx(1'b1, ROWS[i].a, ROWS[i].w, q);
      wbx(1'b0, ROWS[i].a, 32'h0, q);
      chk(q, ROWS[i].r1);
    end
    wbx(1'b1, srs_pkg::BRIDGE_OFS, 32'h0000_0201, q);
    chk(32'({ds, vb}), 32'h0000_005f);
    wbx(1'b1, srs_pkg::BRIDGE_OFS, 32'h0, q);
    lup <= 5'h05;
    wbx(1'b1, srs_pkg::SWITCH_CONTROL_REG_OFS, 32'h0000_0002, q);
    repeat (3) @(posedge clk);
    chk(32'({hot_seen, ds_at, vb_at}), 32'h0000_04bf);
    wbx(1'b0, srs_pkg::STICKY_OFS, 32'h0, q);
    chk(q, 32'h1234_5678);
    wbx(1'b0, srs_pkg::GPIO_OFS, 32'h0, q);
    chk(q, 32'h0);
    // upstream link hot reset event, one cycle
    lhot <= 1'b1;
    @(posedge clk);
    lhot <= 1'b0;
    @(posedge clk);
    chk(32'({hot, srst}), 32'h3);
    wbx(1'b1, srs_pkg::GPIO_OFS, 32'h0000_1f1f, q);
    chk(32'({oe, gout}), 32'h3ff);
    nerr <= 1'b1;
    wbx(1'b1, srs_pkg::SWITCH_CONTROL_REG_OFS, 32'h0000_0001, q);
    @(posedge clk);
    chk(32'({srst, oe, gout}), 32'h0000_0400);
    waitl(1'b1);
    waitl(1'b0);
    wbx(1'b0, srs_pkg::SMBSTS_OFS, 32'h0, q);
    chk(q, 32'h0000_0033);
    chk(32'(ord_bad), 32'h0);
    // pin reset in mid-run with a reserved mode and the fast serial rate
    pins <= '{1'b0, '{3'h2, 1'b0, 4'h5}};
    repeat (4) @(posedge clk);
    pins.rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    chk(32'({nload, retry, slow, div}), 32'h0000_009c);
    wbx(1'b0, srs_pkg::BOOT_OFS, 32'h0, q);
    chk(q, 32'h0000_1290);
    test_done();
  end
endmodule : switch_reset_sequencer_tb
